//--- core/hsfm_pkg.sv
/*
 * constants, register map and state encoding of the hot-swap fault manager.
 * assumes a 20 MHz hclk; all other files except the analog model import this package whole.
 */
package hsfm_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int TICK_SHORT_US  = 32;
	localparam int TICK_LONG_US   = 128;
	localparam int DUR_SHORT_US   = 500;
	localparam int DUR_LONG_US    = 2000;
	localparam int DOWN_RATIO     = 128;
	localparam int START_SENSE_MV = 50;
	localparam int COOL_DROP_C    = 20;
	localparam int TICK_SHORT_CYC = (TICK_SHORT_US * 1000) / CLK_PERIOD_NS;
	localparam int TICK_LONG_CYC  = (TICK_LONG_US * 1000) / CLK_PERIOD_NS;
	localparam int OC_LIMIT_SHORT = (DUR_SHORT_US + TICK_SHORT_US - 1) / TICK_SHORT_US;
	localparam int OC_LIMIT_LONG  = (DUR_LONG_US + TICK_LONG_US - 1) / TICK_LONG_US;
	localparam int OFF_TIME_TICKS = 16;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFF       = 8'h00;
	localparam logic [7:0] STATUS_OFF     = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFF = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFF   = 8'h0c;

	localparam int CTRL_LATCHED_BIT = 0;
	localparam int CTRL_LONG_BIT    = 1;
	localparam int CTRL_PG_LOW_BIT  = 2;
	localparam int CTRL_W           = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_GATE_BIT  = 4;
	localparam int STAT_PG_BIT    = 5;
	localparam int STAT_PINS_LSB  = 8;
	localparam int STAT_INTEG_LSB = 16;
	localparam int STAT_OFF_LSB   = 24;

	localparam int IRQ_OC_BIT     = 0;
	localparam int IRQ_THERM_BIT  = 1;
	localparam int IRQ_SUPPLY_BIT = 2;
	localparam int IRQ_PG_BIT     = 3;
	localparam int IRQ_W          = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

	// synchronised pin vector positions
	localparam int PIN_LOW_SUPPLY  = 0;
	localparam int PIN_HIGH_SUPPLY = 1;
	localparam int PIN_LOCKOUT_OK  = 2;
	localparam int PIN_SENSE_OVER  = 3;
	localparam int PIN_THERM_TRIP  = 4;
	localparam int PIN_THERM_COOL  = 5;
	localparam int PIN_DRAIN_LOW   = 6;
	localparam int PIN_W           = 7;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ON    = 3'b001,
		ST_HOLD  = 3'b010,
		ST_COOL  = 3'b011,
		ST_LATCH = 3'b100
	} state_t;

endpackage

//--- core/hsfm_tick_gen.sv
/*
 * free-running timebase: one-cycle tick every 32 us or 128 us.
 * assumes hclk at the package rate; long_sel may change at any time.
 */
`timescale 1ns/1ps
module hsfm_tick_gen
	import hsfm_pkg::*;
#(
	parameter int SHORT_CYC = TICK_SHORT_CYC,
	parameter int LONG_CYC  = TICK_LONG_CYC
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic long_sel,
	output logic      tick
);

	logic [11:0] cnt_r;
	logic [11:0] last;

	assign last = long_sel ? 12'(LONG_CYC - 1) : 12'(SHORT_CYC - 1);
	assign tick = (cnt_r >= last);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 12'h000;
		end else if (tick) begin
			cnt_r <= 12'h000;
		end else begin
			cnt_r <= cnt_r + 12'h001;
		end
	end

endmodule // hsfm_tick_gen

//--- core/hot_swap_fault_manager.sv
/*
 * gate-enable and fault control of a hot-swap controller, with an
 * ahb-lite register slave. comparator outputs arrive asynchronously on
 * pins and are synchronised here; hclk runs at 20 MHz.
 */
// Summary of operation
// - gate turns on only with supply in range, above lockout, and sense below 50 mV.
// - any detected fault drops gate enable.
// - while overcurrent is present the integrator counts up once per 32 us or 128 us tick.
// - overcurrent shorter than one tick still counts one full tick.
// - an integrator reaching the 500 us (or 2 ms) limit raises an overcurrent fault.
// - without overcurrent the integrator counts down 128 times slower than it counts up.
// - repeated pulses with duty above 1/128 therefore build up to a fault.
// - a thermal trip drops gate enable.
// - autoretry holds off for the off-time and restarts only once the die has cooled 20 C.
// - latched mode holds the gate off after a thermal fault until a supply toggle or reset.
// - a latched restart by the low supply input still waits the off-time.
// - variant bits pick autoretry or latched, 0.5 or 2 ms limit, and power-good polarity.
// - after overcurrent, autoretry restarts after the off-time; latched waits for a toggle.
// - low supply input going low resets a tripped breaker in latched mode.
// - an overvoltage alone never drops power good once asserted.
`timescale 1ns/1ps
module hot_swap_fault_manager
	import hsfm_pkg::*;
#(
	parameter int INTEG_W  = 5,
	parameter int OFF_W    = 16,
	parameter int OFF_TICKS = OFF_TIME_TICKS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        low_supply_input,
	input  wire logic        high_supply_input,
	input  wire logic        supply_lockout_high_level,
	input  wire logic        current_sense_voltage,
	input  wire logic        thermal_trip,
	input  wire logic        thermal_cooled,
	input  wire logic        drain_low,
	output logic             gate_enable,
	output logic             power_good_output,
	output logic             irq
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] sync1_r;
	logic [PIN_W-1:0] pins_r;

	assign pins_raw = {drain_low, thermal_cooled, thermal_trip,
		current_sense_voltage, supply_lockout_high_level,
		high_supply_input, low_supply_input};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_r[gi] <= 1'b0;
					pins_r[gi]  <= 1'b0;
				end else begin
					sync1_r[gi] <= pins_raw[gi];
					pins_r[gi]  <= sync1_r[gi];
				end
			end
		end
	endgenerate

	logic uv_ok;
	logic ov_high;
	logic lockout_ok;
	logic sense_over;
	logic therm_trip;
	logic therm_cool;
	logic drain_is_low;

	assign uv_ok        = pins_r[PIN_LOW_SUPPLY];
	assign ov_high      = pins_r[PIN_HIGH_SUPPLY];
	assign lockout_ok   = pins_r[PIN_LOCKOUT_OK];
	assign sense_over   = pins_r[PIN_SENSE_OVER];
	assign therm_trip   = pins_r[PIN_THERM_TRIP];
	assign therm_cool   = pins_r[PIN_THERM_COOL];
	assign drain_is_low = pins_r[PIN_DRAIN_LOW];

	// ------------------------------------------------------------------
	// control register and timebase
	// ------------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_r;
	logic              latched_mode;
	logic              long_mode;
	logic              pg_active_low;
	logic              tick;

	assign latched_mode  = ctrl_r[CTRL_LATCHED_BIT];
	assign long_mode     = ctrl_r[CTRL_LONG_BIT];
	assign pg_active_low = ctrl_r[CTRL_PG_LOW_BIT];

	hsfm_tick_gen u_tick (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.long_sel (long_mode),
		.tick     (tick)
	);

	// ------------------------------------------------------------------
	// overcurrent integrator
	// ------------------------------------------------------------------
	state_t             state_r;
	state_t             state_nxt;
	logic               oc_seen_r;
	logic               sense_q_r;
	logic               oc_hit;
	logic [INTEG_W-1:0] integ_r;
	logic [INTEG_W-1:0] oc_limit;
	logic [6:0]         down_pre_r;
	logic               oc_fault;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense_q_r <= 1'b0;
		end else begin
			sense_q_r <= sense_over;
		end
	end

	// a new overcurrent inside the tick window counts for the whole tick; one that
	// only runs over a tick boundary is not credited a second time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oc_seen_r <= 1'b0;
		end else if (tick) begin
			oc_seen_r <= 1'b0;
		end else if (sense_over && !sense_q_r) begin
			oc_seen_r <= 1'b1;
		end
	end

	assign oc_hit   = oc_seen_r | sense_over;
	assign oc_limit = long_mode ? INTEG_W'(OC_LIMIT_LONG) : INTEG_W'(OC_LIMIT_SHORT);
	assign oc_fault = (integ_r >= oc_limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			integ_r    <= '0;
			down_pre_r <= 7'h00;
		end else if (state_r != ST_ON) begin
			integ_r    <= '0;
			down_pre_r <= 7'h00;
		end else if (tick && oc_hit) begin
			down_pre_r <= 7'h00;
			if (!oc_fault) begin
				integ_r <= integ_r + INTEG_W'(1);
			end
		end else if (tick) begin
			down_pre_r <= down_pre_r + 7'h01;
			if (down_pre_r == 7'(DOWN_RATIO - 1) && integ_r != '0) begin
				integ_r <= integ_r - INTEG_W'(1);
			end
		end
	end

	// ------------------------------------------------------------------
	// gate state machine
	// ------------------------------------------------------------------
	logic             supply_ok;
	logic             start_ok;
	logic             fault_now;
	logic [OFF_W-1:0] off_cnt_r;
	logic             off_done;
	logic             therm_cause_r;

	assign supply_ok = uv_ok & ~ov_high & lockout_ok;
	assign start_ok  = supply_ok & ~sense_over;
	assign fault_now = oc_fault | therm_trip;
	assign off_done  = (off_cnt_r == '0);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start_ok && !therm_trip) begin
					state_nxt = ST_ON;
				end
			end
			ST_ON: begin
				if (fault_now) begin
					state_nxt = latched_mode ? ST_LATCH : ST_HOLD;
				end else if (!supply_ok) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (off_done) begin
					if (therm_cause_r && !latched_mode && !therm_cool) begin
						state_nxt = ST_COOL;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_COOL: begin
				if (therm_cool) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_LATCH: begin
				if (!uv_ok) begin
					state_nxt = ST_HOLD;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			therm_cause_r <= 1'b0;
		end else if (state_r == ST_ON && fault_now) begin
			therm_cause_r <= therm_trip;
		end
	end

	// off-time counted in ticks from entry to hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			off_cnt_r <= '0;
		end else if (state_r != ST_HOLD && state_nxt == ST_HOLD) begin
			off_cnt_r <= OFF_W'(OFF_TICKS);
		end else if (state_r == ST_HOLD && tick && !off_done) begin
			off_cnt_r <= off_cnt_r - OFF_W'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_enable <= 1'b0;
		end else begin
			gate_enable <= (state_nxt == ST_ON);
		end
	end

	// ------------------------------------------------------------------
	// power good
	// ------------------------------------------------------------------
	logic pg_r;
	logic pg_clear;

	// an overvoltage alone is not among the clearing causes
	assign pg_clear = ~uv_ok | ~lockout_ok | (state_r == ST_HOLD)
		| (state_r == ST_LATCH) | (state_r == ST_COOL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pg_r <= 1'b0;
		end else if (pg_clear) begin
			pg_r <= 1'b0;
		end else if (state_r == ST_ON && drain_is_low) begin
			pg_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_good_output <= 1'b0;
		end else begin
			power_good_output <= pg_r ^ pg_active_low;
		end
	end

	// ------------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------------
	logic       acc_ok;
	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	logic       wr_ctrl;
	logic       wr_w1c;
	logic       wr_mask;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc_ok    = hsel & hready & htrans[1] & (hsize == 3'b010);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc_ok & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	assign wr_ctrl = wr_pend_r && wr_addr_r == CTRL_OFF;
	assign wr_w1c  = wr_pend_r && wr_addr_r == IRQ_STATUS_OFF;
	assign wr_mask = wr_pend_r && wr_addr_r == IRQ_MASK_OFF;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= hwdata[CTRL_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;

	always_comb begin
		irq_ev                 = '0;
		irq_ev[IRQ_OC_BIT]     = (state_r == ST_ON) & oc_fault;
		irq_ev[IRQ_THERM_BIT]  = (state_r == ST_ON) & therm_trip;
		irq_ev[IRQ_SUPPLY_BIT] = (state_r == ST_ON) & ~supply_ok;
		irq_ev[IRQ_PG_BIT]     = ~pg_r & ~pg_clear & (state_r == ST_ON) & drain_is_low;
	end

	assign irq_clr = wr_w1c ? hwdata[IRQ_W-1:0] : '0;

	// set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_r <= '0;
		end else begin
			irq_status_r <= (irq_status_r & ~irq_clr) | irq_ev;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_mask) begin
			irq_mask_r <= hwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_status_r & ~irq_clr) | irq_ev) & irq_mask_r);
		end
	end

	// ------------------------------------------------------------------
	// read data, sampled in the address phase
	// ------------------------------------------------------------------
	logic [31:0] status_word;
	logic [31:0] rd_nxt;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_STATE_LSB +: 3]      = state_r;
		status_word[STAT_GATE_BIT]            = gate_enable;
		status_word[STAT_PG_BIT]              = pg_r;
		status_word[STAT_PINS_LSB +: PIN_W]   = pins_r;
		status_word[STAT_INTEG_LSB +: INTEG_W] = integ_r;
		status_word[STAT_OFF_LSB +: 8]        = off_cnt_r[7:0];
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (haddr[7:0])
			CTRL_OFF:       rd_nxt[CTRL_W-1:0] = ctrl_r;
			STATUS_OFF:     rd_nxt = status_word;
			IRQ_STATUS_OFF: rd_nxt[IRQ_W-1:0] = irq_status_r;
			IRQ_MASK_OFF:   rd_nxt[IRQ_W-1:0] = irq_mask_r;
			default:        rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc_ok && !hwrite) begin
			hrdata <= rd_nxt;
		end
	end

endmodule // hot_swap_fault_manager

//--- verif/hsfm_monitor.sv
/*
 * checker of gate, power-good and restart behaviour of the fault manager.
 * sees only the top-level ports; bound from the bench top file.
 */
`timescale 1ns/1ps
module hsfm_monitor
	import hsfm_pkg::*;
#(
	parameter int OFF_TICKS = OFF_TIME_TICKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic low_supply_input,
	input wire logic high_supply_input,
	input wire logic supply_lockout_high_level,
	input wire logic current_sense_voltage,
	input wire logic thermal_trip,
	input wire logic drain_low,
	input wire logic gate_enable,
	input wire logic power_good_output
);
	localparam int MIN_OFF = (OFF_TICKS - 1) * TICK_SHORT_CYC;
	localparam int OC_MAX  = (OC_LIMIT_LONG + 2) * TICK_LONG_CYC;

	logic        supply_ok;
	logic        gate_q_r;
	logic        hold_r;
	int unsigned off_cnt_r;
	int unsigned oc_cnt_r;

	assign supply_ok = low_supply_input && !high_supply_input && supply_lockout_high_level;

	// ------------------------------------------------------------------
	// off-time and overcurrent counters
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_q_r  <= 1'b0;
			hold_r    <= 1'b0;
			off_cnt_r <= 0;
			oc_cnt_r  <= 0;
		end else begin
			gate_q_r <= gate_enable;
			oc_cnt_r <= (gate_enable && current_sense_voltage) ? oc_cnt_r + 1 : 0;
			// a fall with the supply in range is a fault fall
			if (gate_q_r && !gate_enable && supply_ok) begin
				hold_r    <= 1'b1;
				off_cnt_r <= 0;
			end else if (gate_enable) begin
				hold_r <= 1'b0;
			end else begin
				off_cnt_r <= off_cnt_r + 1;
			end
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence sense_blocked_s;
		current_sense_voltage[*5] ##0 !gate_enable;
	endsequence

	sequence ov_only_s;
		$rose(high_supply_input) && $stable(drain_low) ##0 (low_supply_input &&
			supply_lockout_high_level && !thermal_trip && !current_sense_voltage)[*6];
	endsequence

	a_low_supply_off: assert property (!low_supply_input[*5] |-> !gate_enable)
		else $error("gate on with low supply");
	a_over_volt_off: assert property (high_supply_input[*5] |-> !gate_enable)
		else $error("gate on during overvoltage");
	a_lockout_off: assert property (!supply_lockout_high_level[*5] |-> !gate_enable)
		else $error("gate on below lockout");
	a_thermal_off: assert property (thermal_trip[*5] |-> !gate_enable)
		else $error("gate on during thermal trip");
	a_sense_blocks: assert property (sense_blocked_s |=> !gate_enable)
		else $error("start with sense high");
	a_ov_keeps_pg: assert property (ov_only_s |-> power_good_output == $past(power_good_output, 5))
		else $error("power good moved on overvoltage");
	a_reset_gate_off: assert property ($rose(hresetn) |-> !gate_enable[*3])
		else $error("gate on right after reset");
	a_restart_hold: assert property ($rose(gate_enable) && hold_r |-> off_cnt_r >= MIN_OFF)
		else $error("restart before off-time");
	a_oc_trip_bound: assert property (gate_enable |-> oc_cnt_r <= OC_MAX)
		else $error("overcurrent never tripped");

endmodule // hsfm_monitor

//--- verif/hsfm_analog_model.sv
/*
 * comparators and pass transistor in front of the fault manager.
 * bench sets conditions; pins change just after the clock edge.
 */
`timescale 1ns/1ps
module hsfm_analog_model #(
	parameter int DRAIN_DLY = 8
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic uv_ok,
	input  wire logic ov_hit,
	input  wire logic lock_ok,
	input  wire logic oc_hit,
	input  wire logic hot,
	input  wire logic cooled,
	input  wire logic gate_enable,
	output logic      low_supply_input,
	output logic      high_supply_input,
	output logic      supply_lockout_high_level,
	output logic      current_sense_voltage,
	output logic      thermal_trip,
	output logic      thermal_cooled,
	output logic      drain_low
);
	int drain_cnt;

	always_ff @(posedge hclk) begin
		low_supply_input          <= uv_ok;
		high_supply_input         <= ov_hit;
		supply_lockout_high_level <= lock_ok;
		current_sense_voltage     <= oc_hit;
		thermal_trip              <= hot;
		thermal_cooled            <= cooled && !hot;
	end

	// drain slews low some cycles after the gate turns on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drain_cnt <= 0;
			drain_low <= 1'b0;
		end else if (!gate_enable) begin
			drain_cnt <= 0;
			drain_low <= 1'b0;
		end else if (drain_cnt == DRAIN_DLY) begin
			drain_low <= 1'b1;
		end else begin
			drain_cnt <= drain_cnt + 1;
		end
	end

endmodule // hsfm_analog_model

//--- verif/tb_top.sv
/*
 * self-checking bench of the fault manager with an ahb-lite master.
 * assumes the analog model and monitor files are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
	import hsfm_pkg::*;
	localparam int OFF = 2;
	localparam int TK  = TICK_SHORT_CYC;
	localparam int TL  = TICK_LONG_CYC;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, seed, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        gate_enable, power_good_output, irq, drain_low;
	logic        low_supply_input, high_supply_input, supply_lockout_high_level;
	logic        current_sense_voltage, thermal_trip, thermal_cooled;
	logic        uv_ok, ov_hit, lock_ok, oc_hit, hot, cooled;
	int          errors, comparisons, n;

	hot_swap_fault_manager #(.OFF_TICKS(OFF)) hot_swap_fault_manager_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .low_supply_input(low_supply_input),
		.high_supply_input(high_supply_input), .supply_lockout_high_level(supply_lockout_high_level),
		.current_sense_voltage(current_sense_voltage), .thermal_trip(thermal_trip),
		.thermal_cooled(thermal_cooled), .drain_low(drain_low), .gate_enable(gate_enable),
		.power_good_output(power_good_output), .irq(irq));

	hsfm_analog_model hsfm_analog_model_i (.hclk(hclk), .hresetn(hresetn), .uv_ok(uv_ok),
		.ov_hit(ov_hit), .lock_ok(lock_ok), .oc_hit(oc_hit), .hot(hot), .cooled(cooled),
		.gate_enable(gate_enable), .low_supply_input(low_supply_input),
		.high_supply_input(high_supply_input), .supply_lockout_high_level(supply_lockout_high_level),
		.current_sense_voltage(current_sense_voltage), .thermal_trip(thermal_trip),
		.thermal_cooled(thermal_cooled), .drain_low(drain_low));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic pg_pin(input logic good, input logic low_pol);
		return good ^ low_pol;
	endfunction

	task automatic report_and_stop();
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_rng(input int v, input int lo, input int hi);
		comparisons++;
		if (v < lo || v > hi) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int c;
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		c = 0;
		do begin @(posedge hclk); c++; end while (hreadyout !== 1'b1 && c < 16);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do begin @(posedge hclk); c++; end while (hreadyout !== 1'b1 && c < 32);
		rd = hrdata;
		if (c >= 32) begin errors++; report_and_stop(); end
	endtask

	task automatic wait_gate(input logic v);
		n = 0;
		while (gate_enable !== v) begin
			@(posedge hclk);
			n++;
			if (n > 80 * TK) begin errors++; report_and_stop(); end
		end
	endtask

	// ------------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	initial begin
		seed = 32'h22; errors = 0; comparisons = 0;
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
		hsize = 3'b010; hwdata = 32'h0;
		uv_ok = 1'b1; ov_hit = 1'b0; lock_ok = 1'b1; oc_hit = 1'b1; hot = 1'b0; cooled = 1'b1;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(gate_enable, 1'b0);
		check({power_good_output, irq}, 2'b00);
		bus(1'b0, CTRL_OFF, 32'h0); check(rd, {29'h0, CTRL_RST});
		bus(1'b0, IRQ_MASK_OFF, 32'h0); check(rd, {28'h0, IRQ_MASK_RST});
		bus(1'b0, 8'h40, 32'h0); check(rd, 32'h0);
		bus(1'b1, IRQ_MASK_OFF, 32'hf);
		repeat (20) @(posedge hclk);
		check(gate_enable, 1'b0);
		oc_hit <= 1'b0;
		wait_gate(1'b1); check(gate_enable, 1'b1);
		repeat (40) @(posedge hclk);
		check(power_good_output, pg_pin(1'b1, 1'b0));
		check(irq, 1'b1);
		bus(1'b1, IRQ_STATUS_OFF, 32'hf);
		repeat (3) @(posedge hclk);
		check(irq, 1'b0);
		ov_hit <= 1'b1;
		repeat (10) @(posedge hclk);
		check(gate_enable, 1'b0);
		check(power_good_output, 1'b1);
		ov_hit <= 1'b0;
		wait_gate(1'b1);
		repeat (next_rand() % 8 + 1) @(posedge hclk);
		oc_hit <= 1'b1;
		repeat (next_rand() % 2 + 1) @(posedge hclk);
		oc_hit <= 1'b0;
		repeat (TK + 20) @(posedge hclk);
		bus(1'b0, STATUS_OFF, 32'h0); check({27'h0, rd[20:16]}, 32'h1);
		oc_hit <= 1'b1;
		wait_gate(1'b0); check_rng(n, (OC_LIMIT_SHORT - 2) * TK, OC_LIMIT_SHORT * TK);
		oc_hit <= 1'b0;
		bus(1'b0, IRQ_STATUS_OFF, 32'h0); check(rd[IRQ_OC_BIT], 1'b1);
		wait_gate(1'b1); check_rng(n, (OFF - 1) * TK - 20, (OFF + 1) * TK);
		bus(1'b1, IRQ_STATUS_OFF, 32'hf);
		bus(1'b1, CTRL_OFF, 32'h4);
		repeat (40) @(posedge hclk);
		check(power_good_output, pg_pin(1'b1, 1'b1));
		bus(1'b1, CTRL_OFF, 32'h0);
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, CTRL_OFF, m);
			hot <= 1'b1;
			cooled <= 1'b0;
			repeat (10) @(posedge hclk);
			check(gate_enable, 1'b0);
			hot <= 1'b0;
			if (m == 1) cooled <= 1'b1;
			repeat ((OFF + 2) * TK) @(posedge hclk);
			check(gate_enable, 1'b0);
			if (m == 0) cooled <= 1'b1;
			else begin
				uv_ok <= 1'b0;
				repeat (10) @(posedge hclk);
				uv_ok <= 1'b1;
			end
			wait_gate(1'b1);
			if (m == 1) check_rng(n, (OFF - 1) * TK - 20, (OFF + 2) * TK);
		end
		bus(1'b1, CTRL_OFF, 32'h2);
		oc_hit <= 1'b1;
		wait_gate(1'b0);
		check_rng(n, (OC_LIMIT_LONG - 2) * TL, (OC_LIMIT_LONG + 1) * TL);
		oc_hit <= 1'b0;
		report_and_stop();
	end

endmodule // tb_top

bind hot_swap_fault_manager hsfm_monitor #(.OFF_TICKS(OFF_TICKS)) hsfm_monitor_i (.hclk(hclk),
	.hresetn(hresetn), .low_supply_input(low_supply_input),
	.high_supply_input(high_supply_input), .supply_lockout_high_level(supply_lockout_high_level),
	.current_sense_voltage(current_sense_voltage), .thermal_trip(thermal_trip),
	.drain_low(drain_low), .gate_enable(gate_enable), .power_good_output(power_good_output));
